/* File: hw/rpe_pkg.sv */
// constants for the reset, low-power and programming-entry block
// assumes a 40 MHz system clock sampling the oscillator input pin
package rpe_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          OSC_PER_MCYCLE    = 12;              // oscillator periods per machine cycle
    localparam int          RESET_MCYCLES     = 2;               // machine cycles of high level
    localparam int          RESET_OSC_PERIODS = OSC_PER_MCYCLE * RESET_MCYCLES; // 24
    // ------------------------------------------------------------
    // key, address and memory layout
    // ------------------------------------------------------------
    localparam int          KEY_BITS          = 10;              // serial key length
    localparam logic [9:0]  KEY_PATTERN_DEF   = 10'h2A5;         // arbitrary default key
    localparam int          ADDR_BITS         = 10;              // program address width
    localparam int          HI_ADDR_BITS      = 3;               // used bits of high byte
    localparam int          PROG_MEM_BYTES    = 1024;            // program memory size
    // ------------------------------------------------------------
    // fixed vectors
    // ------------------------------------------------------------
    localparam logic [9:0]  VEC_RESET         = 10'h000;         // reset entry
    localparam logic [9:0]  VEC_IRQ_A         = 10'h003;         // first external interrupt
    localparam logic [9:0]  VEC_TIMER         = 10'h00B;         // counter/timer
    localparam logic [9:0]  VEC_IRQ_B         = 10'h013;         // second external interrupt
    // ------------------------------------------------------------
    // power control bit positions and reset value
    // ------------------------------------------------------------
    localparam int          PCTL_IDLE_BIT     = 0;               // idle_request_bit
    localparam int          PCTL_PDN_BIT      = 1;               // powerdown_request_bit
    localparam logic [1:0]  PCTL_RESET        = 2'h0;            // both requests clear
    // ------------------------------------------------------------
    // port 1 alternate functions
    // ------------------------------------------------------------
    localparam int          P1_IRQ_A_BIT      = 5;               // ext_irq_a
    localparam int          P1_IRQ_B_BIT      = 6;               // ext_irq_b
    localparam int          P1_COUNT_BIT      = 7;               // count_input_pin
    localparam logic [7:0]  PORT_RESET        = 8'hFF;           // port latch reset value
    // operating modes
    typedef enum logic [1:0] {RPE_RUN, RPE_IDLE, RPE_PDOWN, RPE_PROG} rpe_mode_e;
endpackage : rpe_pkg

/* File: hw/rpe_sync2.sv */
// two-flip-flop synchroniser, one bit per lane
// assumes asynchronous pin inputs and a single system clock
`timescale 1ns/1ps
`default_nettype none
module rpe_sync2 #(
    parameter int W = 1                       // lanes
) (
    input  wire logic         clock_in,       // system clock
    input  wire logic         reset_n_in,     // sync reset, low
    input  wire logic [W-1:0] async_in,       // pin levels
    output logic      [W-1:0] sync_out        // synchronised levels
);
    logic [W-1:0] meta_r;
    // first stage feeds only the second
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // rpe_sync2
`default_nettype wire

/* File: hw/rpe_progmem.sv */
// program memory array with one address shared by the write and the registered read
// assumes address and data are stable when the write strobe is high
`timescale 1ns/1ps
`default_nettype none
module rpe_progmem #(
    parameter int DEPTH = rpe_pkg::PROG_MEM_BYTES,  // bytes
    parameter int AW    = rpe_pkg::ADDR_BITS        // address width
) (
    input  wire logic          clock_in,            // system clock
    input  wire logic          wr_en_in,            // write strobe
    input  wire logic [AW-1:0] addr_in,             // byte address
    input  wire logic [7:0]    wr_data_in,          // byte to write
    output logic      [7:0]    rd_data_out          // registered read
);
    logic [7:0] mem [DEPTH];
    // write and registered read on the same edge; the read returns the old contents
    always_ff @(posedge clock_in)
    begin
        if (wr_en_in)
            mem[addr_in] <= wr_data_in;
        rd_data_out <= mem[addr_in];
    end
endmodule // rpe_progmem
`default_nettype wire

/* File: hw/rpe_ctrl.sv */
// reset, low-power and programming-entry control of a small controller
// assumes the oscillator pin is sampled by a faster clock_in and that the
// core supplies idle/power-down requests and its interrupt handshake
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reset pin high for 24 oscillator periods resets the device
// - after reset a ten-bit key, LSB first, enters programming state
// - programming address arrives on port 3 in two halves
// - select low latches port 3 as address low byte
// - select high takes port 3 as address high byte
// - only the three low port bits form the high address byte
// - verify select high enables port 1 data outputs
// - verify select low writes port 1 data to addressed location
// - port 1 drives memory contents on verify, accepts data on program
// - port 1 bits 5 and 6 serve as external interrupt inputs
// - port 1 bit 7 serves as timer count input
// - oscillator input goes through a divide-by-two stage
// - idle follows its request instruction; core halts, peripherals run
// - idle keeps core state, RAM and special function registers
// - any enabled interrupt ends idle at its service routine
// - reset during idle restarts like power-on reset
// - power-down stops oscillator after request; keeps RAM only
// - only hardware reset leaves power-down
// - idle and power-down requests live in the power control register
// - ports keep last written data during idle and power-down
// - program memory is 1024 bytes, no external fetch or long jumps
// - execution starts at address zero after reset
// - interrupt vectors are 003, 00B and 013
module rpe_ctrl #(
    parameter logic [9:0] KEY_PATTERN = rpe_pkg::KEY_PATTERN_DEF  // entry key
) (
    input  wire logic       clock_in,            // 40 MHz system clock
    input  wire logic       reset_n_in,          // sync reset, low
    input  wire logic       osc_input_in,        // oscillator pin level
    input  wire logic       reset_pin_in,        // device reset pin, high active
    input  wire logic       address_byte_select_in,  // 0 low, 1 high byte
    input  wire logic       verify_program_select_in, // 1 verify, 0 program
    input  wire logic [7:0] port3_in,            // port 3 pin levels
    input  wire logic [7:0] port1_in,            // port 1 pin levels
    input  wire logic [7:0] port1_latch_in,      // core port 1 data latch
    input  wire logic [7:0] port3_latch_in,      // core port 3 data latch
    input  wire logic       pctl_wr_in,          // core writes power control
    input  wire logic [1:0] pctl_wdata_in,       // power control write data
    input  wire logic       instr_done_in,       // core finished an instruction
    input  wire logic [2:0] irq_pending_in,      // enabled irq: a, timer, b
    output logic            core_reset_out,      // internal reset
    output logic            core_run_out,        // core clock enable
    output logic            periph_run_out,      // peripheral clock enable
    output logic            osc_stop_out,        // oscillator stopped
    output logic            prog_state_out,      // programming state
    output logic [1:0]      power_control_register_out, // request bits
    output logic            vector_load_out,     // load program counter
    output logic [9:0]      vector_addr_out,     // entry address
    output logic            ext_irq_a_out,       // port 1 bit 5 alternate
    output logic            ext_irq_b_out,       // port 1 bit 6 alternate
    output logic            count_input_pin_out, // port 1 bit 7 alternate
    output logic            clk_div2_out,        // divided machine clock
    output logic [7:0]      port1_out,           // port 1 output data
    output logic [7:0]      port1_oe_out,        // port 1 output enable
    output logic [7:0]      port3_out,           // port 3 output data
    output logic [7:0]      port3_oe_out         // port 3 output enable
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [19:0] pins_s;
    logic        osc_s, rst_s, bsel_s, vsel_s;
    logic [7:0]  p3_s, p1_s;
    rpe_sync2 #(.W(20)) u_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   ({osc_input_in, reset_pin_in, address_byte_select_in,
                      verify_program_select_in, port3_in, port1_in}),
        .sync_out   (pins_s)
    );
    assign {osc_s, rst_s, bsel_s, vsel_s, p3_s, p1_s} = pins_s;
    // rising edge of the sampled oscillator input
    logic osc_d_r, osc_rise;
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
            osc_d_r <= 1'b0;
        else
            osc_d_r <= osc_s;
    end
    assign osc_rise = osc_s & ~osc_d_r;
    // ------------------------------------------------------------
    // divide-by-two machine clock
    // ------------------------------------------------------------
    // toggling only on rising edges makes the duty cycle irrelevant
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
            clk_div2_out <= 1'b0;
        else if (osc_rise)
            clk_div2_out <= ~clk_div2_out;
    end

    // ------------------------------------------------------------
    // reset pin duration counter
    // ------------------------------------------------------------
    localparam int RCW = $clog2(rpe_pkg::RESET_OSC_PERIODS + 1);
    localparam logic [RCW-1:0] RST_LIMIT = RCW'(rpe_pkg::RESET_OSC_PERIODS);
    logic [RCW-1:0] rst_cnt_r;
    logic           rst_hit;
    // count oscillator periods of continuous high level; a low restarts
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in || !rst_s)
            rst_cnt_r <= '0;
        else if (osc_rise && rst_cnt_r != RST_LIMIT)
            rst_cnt_r <= rst_cnt_r + 1'b1;
    end
    assign rst_hit = rst_s && rst_cnt_r == RST_LIMIT;
    // ------------------------------------------------------------
    // serial key capture
    // ------------------------------------------------------------
    logic [rpe_pkg::KEY_BITS-1:0] key_sr_r;
    logic [3:0]                   key_cnt_r;
    logic                         key_arm_r;
    // armed once the reset pin drops after a reset; bits enter at the top
    // so the first (least significant) bit ends at bit 0
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in || rst_hit)
        begin
            key_sr_r  <= '0;
            key_cnt_r <= 4'h0;
            key_arm_r <= 1'b1;
        end
        else if (key_arm_r && osc_rise && key_cnt_r != 4'(rpe_pkg::KEY_BITS))
        begin
            key_sr_r  <= {rst_s, key_sr_r[rpe_pkg::KEY_BITS-1:1]};
            key_cnt_r <= key_cnt_r + 4'h1;
        end
        else if (key_cnt_r == 4'(rpe_pkg::KEY_BITS))
            key_arm_r <= 1'b0;
    end
    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    rpe_pkg::rpe_mode_e mode_r, mode_nxt;
    logic               irq_wake;
    assign irq_wake = |irq_pending_in;
    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            rpe_pkg::RPE_RUN:
                if (key_arm_r && key_cnt_r == 4'(rpe_pkg::KEY_BITS)
                    && key_sr_r == KEY_PATTERN)
                    mode_nxt = rpe_pkg::RPE_PROG;
                else if (instr_done_in && power_control_register_out[rpe_pkg::PCTL_PDN_BIT])
                    mode_nxt = rpe_pkg::RPE_PDOWN;
                else if (instr_done_in && power_control_register_out[rpe_pkg::PCTL_IDLE_BIT])
                    mode_nxt = rpe_pkg::RPE_IDLE;
            rpe_pkg::RPE_IDLE:
                if (irq_wake)
                    mode_nxt = rpe_pkg::RPE_RUN;
            rpe_pkg::RPE_PDOWN:
                mode_nxt = rpe_pkg::RPE_PDOWN;
            rpe_pkg::RPE_PROG:
                mode_nxt = rpe_pkg::RPE_PROG;
        endcase
    end
    // a hardware reset from any mode returns to run
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in || rst_hit)
            mode_r <= rpe_pkg::RPE_RUN;
        else
            mode_r <= mode_nxt;
    end
    // ------------------------------------------------------------
    // power control register
    // ------------------------------------------------------------
    // request bits clear when their mode is left by interrupt or reset
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in || rst_hit)
            power_control_register_out <= rpe_pkg::PCTL_RESET;
        else if (mode_r == rpe_pkg::RPE_IDLE && irq_wake)
            power_control_register_out[rpe_pkg::PCTL_IDLE_BIT] <= 1'b0;
        else if (pctl_wr_in && mode_r == rpe_pkg::RPE_RUN)
            power_control_register_out <= pctl_wdata_in;
    end
    // ------------------------------------------------------------
    // core and clock enables, vectors
    // ------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            core_reset_out <= 1'b1;
            core_run_out   <= 1'b0;
            periph_run_out <= 1'b0;
            osc_stop_out   <= 1'b0;
            prog_state_out <= 1'b0;
        end
        else
        begin
            core_reset_out <= rst_hit;
            core_run_out   <= mode_nxt == rpe_pkg::RPE_RUN && !rst_hit;
            periph_run_out <= mode_nxt == rpe_pkg::RPE_RUN
                              || mode_nxt == rpe_pkg::RPE_IDLE;
            osc_stop_out   <= mode_nxt == rpe_pkg::RPE_PDOWN;
            prog_state_out <= mode_nxt == rpe_pkg::RPE_PROG;
        end
    end
    // vector select: reset, then irq a, timer, b in fixed priority
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in || rst_hit)
        begin
            vector_load_out <= 1'b1;
            vector_addr_out <= rpe_pkg::VEC_RESET;
        end
        else if (mode_r == rpe_pkg::RPE_IDLE && irq_wake)
        begin
            vector_load_out <= 1'b1;
            vector_addr_out <= irq_pending_in[0] ? rpe_pkg::VEC_IRQ_A
                             : irq_pending_in[1] ? rpe_pkg::VEC_TIMER
                             : rpe_pkg::VEC_IRQ_B;
        end
        else
            vector_load_out <= 1'b0;
    end
    // ------------------------------------------------------------
    // port 1 alternate inputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            ext_irq_a_out       <= 1'b1;
            ext_irq_b_out       <= 1'b1;
            count_input_pin_out <= 1'b1;
        end
        else if (mode_r != rpe_pkg::RPE_PROG)
        begin
            ext_irq_a_out       <= p1_s[rpe_pkg::P1_IRQ_A_BIT];
            ext_irq_b_out       <= p1_s[rpe_pkg::P1_IRQ_B_BIT];
            count_input_pin_out <= p1_s[rpe_pkg::P1_COUNT_BIT];
        end
    end

    // ------------------------------------------------------------
    // programming address and memory
    // ------------------------------------------------------------
    logic [7:0] addr_lo_r;
    logic [2:0] addr_hi_r;
    logic       wr_en_r;
    logic [7:0] mem_rd;
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            addr_lo_r <= 8'h00;
            addr_hi_r <= 3'h0;
        end
        else if (mode_r == rpe_pkg::RPE_PROG)
        begin
            if (!bsel_s)
                addr_lo_r <= p3_s;
            else
                addr_hi_r <= p3_s[rpe_pkg::HI_ADDR_BITS-1:0];
        end
    end
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
            wr_en_r <= 1'b0;
        else
            wr_en_r <= mode_r == rpe_pkg::RPE_PROG && !vsel_s;
    end
    rpe_progmem #(.DEPTH(rpe_pkg::PROG_MEM_BYTES), .AW(rpe_pkg::ADDR_BITS)) u_mem (
        .clock_in    (clock_in),
        .wr_en_in    (wr_en_r),
        .addr_in     ({addr_hi_r[rpe_pkg::ADDR_BITS-9:0], addr_lo_r}),
        .wr_data_in  (p1_s),
        .rd_data_out (mem_rd)
    );
    // ------------------------------------------------------------
    // port drivers
    // ------------------------------------------------------------
    // latches are followed in run and frozen in idle or power-down
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            port1_out    <= rpe_pkg::PORT_RESET;
            port1_oe_out <= 8'h00;
            port3_out    <= rpe_pkg::PORT_RESET;
            port3_oe_out <= 8'h00;
        end
        else if (mode_r == rpe_pkg::RPE_PROG)
        begin
            port1_out    <= mem_rd;
            port1_oe_out <= vsel_s ? 8'hFF : 8'h00;
            port3_oe_out <= 8'h00;
        end
        else if (mode_r == rpe_pkg::RPE_RUN)
        begin
            port1_out    <= port1_latch_in;
            port1_oe_out <= ~port1_latch_in;
            port3_out    <= port3_latch_in;
            port3_oe_out <= ~port3_latch_in;
        end
        // idle and power-down hold last values
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_pd_entered;
        mode_r == rpe_pkg::RPE_PDOWN;
    endsequence
    a_reset_after_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        rst_hit |=> core_reset_out && mode_r == rpe_pkg::RPE_RUN)
        else $error("reset hold did not reset");
    a_reset_count_full: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        rst_hit |-> rst_cnt_r == RST_LIMIT)
        else $error("reset asserted before two machine cycles");
    a_pd_sticky: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        s_pd_entered ##0 !rst_hit |=> mode_r == rpe_pkg::RPE_PDOWN)
        else $error("power-down left without reset");
    a_pd_osc_stop: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        s_pd_entered ##1 !rst_hit |-> osc_stop_out)
        else $error("oscillator not stopped in power-down");
    a_idle_wake_vec: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_r == rpe_pkg::RPE_IDLE && irq_pending_in[0] && !rst_hit
        |=> vector_load_out && vector_addr_out == 10'h003)
        else $error("idle wake vector wrong");
    a_verify_drive: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_r == rpe_pkg::RPE_PROG && vsel_s |=> port1_oe_out == 8'hFF)
        else $error("port 1 not driven in verify");
    a_hi_addr_bits: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_r == rpe_pkg::RPE_PROG && bsel_s |=> addr_hi_r == $past(p3_s[2:0]))
        else $error("high address byte wrong");
    a_idle_ports_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_r == rpe_pkg::RPE_IDLE ##1 mode_r == rpe_pkg::RPE_IDLE
        |-> $stable(port1_out) && $stable(port3_out))
        else $error("ports changed during idle");
    a_idle_core_halt: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_r == rpe_pkg::RPE_IDLE && !irq_wake && !rst_hit
        |=> !core_run_out && periph_run_out)
        else $error("core not halted in idle");
endmodule // rpe_ctrl
`default_nettype wire

/* File: verification/rpe_prog_model.sv */
// programmer and reset source model: oscillator drive and reset pin
// assumes the bench calls key_seq from one process at a time
`timescale 1ns/1ps
`default_nettype none
module rpe_prog_model (
    input  wire logic clock_in,     // system clock
    output logic      osc_out,      // oscillator drive
    output logic      rst_pin_out   // reset pin and key data
);
    // free oscillator, ten system clocks a period; pin pulled low when idle
    initial
    begin
        {osc_out, rst_pin_out} = 2'b00;
        forever
        begin
            repeat (5) @(negedge clock_in);
            osc_out = ~osc_out;
        end
    end
    // reset pulse of n periods, then a key lsb first, pin changes at osc falls
    task automatic key_seq(input int n, input logic [9:0] key);
        @(negedge osc_out);
        rst_pin_out = 1'b1;
        repeat (n) @(negedge osc_out);
        for (int i = 0; i < 10; i++)
        begin
            rst_pin_out = key[i];
            @(negedge osc_out);
        end
        rst_pin_out = 1'b0;
    endtask
endmodule // rpe_prog_model
`default_nettype wire

/* File: verification/reset_power_and_prog_entry_tb_top.sv */
// self-checking bench for reset, low-power and programming-entry control
// assumes rpe_pkg, rpe_ctrl and rpe_prog_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module reset_power_and_prog_entry_tb_top;
    localparam logic [9:0] KEY = 10'h15A;  // bit 0 low so the pin release shows
    logic       clk, rst_n, osc, rpin, bsel, vsel, pwr, done, crun, prun, ostop, prog;
    logic       vld, creset, ia, ib, cnt, div2, v;
    logic [1:0] pwd, pcr;
    logic [2:0] irq;
    logic [7:0] p1_drv, p3_drv, l1, l3, p1o, p1oe, p3o, p3oe, d [4];
    logic [9:0] vad, last_vec, a [4];
    logic [9:0] vecs [3] = '{rpe_pkg::VEC_IRQ_A, rpe_pkg::VEC_TIMER, rpe_pkg::VEC_IRQ_B};
    logic [15:0] oe_keep;
    wire  [7:0] p1_pin = (p1oe & p1o) | (~p1oe & p1_drv);  // device drive wins
    int         bad_count = 0, cmp_count = 0, n_rst = 0, r0;
    rpe_ctrl #(.KEY_PATTERN(KEY)) i_dut (
        .clock_in(clk), .reset_n_in(rst_n), .osc_input_in(osc), .reset_pin_in(rpin),
        .address_byte_select_in(bsel), .verify_program_select_in(vsel),
        .port3_in(p3_drv), .port1_in(p1_pin), .port1_latch_in(l1), .port3_latch_in(l3),
        .pctl_wr_in(pwr), .pctl_wdata_in(pwd), .instr_done_in(done), .irq_pending_in(irq),
        .core_reset_out(creset), .core_run_out(crun), .periph_run_out(prun),
        .osc_stop_out(ostop), .prog_state_out(prog), .power_control_register_out(pcr),
        .vector_load_out(vld), .vector_addr_out(vad), .ext_irq_a_out(ia),
        .ext_irq_b_out(ib), .count_input_pin_out(cnt), .clk_div2_out(div2),
        .port1_out(p1o), .port1_oe_out(p1oe), .port3_out(p3o), .port3_oe_out(p3oe));
    rpe_prog_model u_prog (.clock_in(clk), .osc_out(osc), .rst_pin_out(rpin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("%0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // power control write followed by the end of that instruction
    task automatic pctl_req(input logic [1:0] val);
        {pwr, pwd} = {1'b1, val};
        @(negedge clk);
        {pwr, done} = 2'b01;
        @(negedge clk);
        done = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // address as low byte then high byte, unused high bits as noise
    task automatic put_addr(input logic [9:0] adr);
        {bsel, p3_drv} = {1'b0, adr[7:0]};
        repeat (4) @(negedge clk);
        {bsel, p3_drv} = {1'b1, 5'($urandom), 1'b0, adr[9:8]};
        repeat (4) @(negedge clk);
    endtask
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // counts clock cycles with internal reset high and keeps the last loaded vector
    always @(posedge clk)
    begin
        n_rst <= n_rst + int'(creset);
        if (vld === 1'b1) last_vec <= vad;
    end
    // watchdog
    initial
    begin
        #300000;
        bad_count++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        {rst_n, bsel, pwr, done, irq, pwd, p3_drv} = '0;
        {vsel, p1_drv, l1, l3} = '1;
        r0 = $urandom(32'h20AD650D);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check(last_vec, rpe_pkg::VEC_RESET);
        for (int i = 0; i < 8; i++)
        begin
            p1_drv = 8'($urandom);
            repeat (5) @(negedge clk);
            check({ia, ib, cnt}, {p1_drv[5], p1_drv[6], p1_drv[7]});
        end
        v = div2;
        repeat (10) @(negedge clk);
        check(div2, !v);
        $display("run mode test done");
        for (int i = 0; i < 3; i++)
        begin
            pctl_req(2'h1);
            check({crun, prun, pcr}, 4'b0101);
            irq[i] = 1'b1;
            repeat (6) @(negedge clk);
            irq = '0;
            check({crun, pcr, last_vec}, {3'b100, vecs[i]});
        end
        $display("idle test done");
        pctl_req(2'h2);
        check({crun, prun, ostop}, 3'b001);
        {oe_keep, irq} = {p1oe, p3oe, 3'h7};
        {l1, l3} = 16'($urandom);
        repeat (8) @(negedge clk);
        check({crun, ostop, p1oe, p3oe}, {2'b01, oe_keep});
        check({p1o, p3o}, 16'hFFFF);
        {irq, r0} = {3'h0, n_rst};
        u_prog.key_seq(23, 10'h000);
        repeat (4) @(negedge clk);
        check({31'(n_rst - r0), ostop}, 1);
        u_prog.key_seq(24, KEY ^ 10'h200);
        repeat (8) @(negedge clk);
        check({n_rst > r0, crun, ostop, prog, last_vec}, {4'b1100, 10'h000});
        u_prog.key_seq(30, KEY);
        repeat (8) @(negedge clk);
        check(prog, 1'b1);
        $display("power-down and key test done");
        for (int i = 0; i < 8; i++)
        begin
            if (i < 4) {a[i], d[i]} = {2'(i), (i == 3) ? 8'hFF : 8'($urandom), 8'($urandom)};
            put_addr(a[i % 4]);
            if (i < 4) {vsel, p1_drv} = {1'b0, d[i]};
            repeat (4) @(negedge clk);
            vsel = 1'b1;
            repeat (4) @(negedge clk);
            if (i > 3) check({p1oe, p1o}, {8'hFF, d[i % 4]});
        end
        $display("program and verify test done");
        tally_and_finish();
    end
endmodule // reset_power_and_prog_entry_tb_top
`default_nettype wire
